// [design/blink_divider.v]
/*
  Blink toggle generator: square wave at 6 Hz times a power of two.
  Assumes a free running system clock given by a parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`include "phy_led_mdix_regs.vh"

module blink_divider #(
  parameter CLK_HZ = `CLK_HZ,
  parameter BASE_HZ = `BLINK_BASE_HZ
) (
  input wire clk_i,
  input wire rst_i,
  input wire [1:0] rate_i,
  output reg wave_o
);
  // half period of the slowest rate; faster rates end the count early
  localparam HALF = CLK_HZ / (2 * BASE_HZ);
  localparam [23:0] HALF_CNT = HALF[23:0];

  reg [23:0] count;
  wire [23:0] limit;

  assign limit = (HALF_CNT >> rate_i) - 24'h000001; // RULE6

  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= 24'h000000;
      wave_o <= 1'b0;
    end else if (count >= limit) begin
      count <= 24'h000000;
      wave_o <= ~wave_o;
    end else begin
      count <= count + 24'h000001;
    end
  end
endmodule // blink_divider

`default_nettype wire

// [design/phy_led_and_mdix_control_regs.v]
/*
  Register bank for the elasticity threshold and FIFO status, LED direct
  control and crossover control, with a classic Wishbone slave and an
  interrupt for FIFO underflow/overflow events.
  Assumes the FIFO event, traffic and link inputs and the strap come from
  other clock domains or pins and are synchronised here.
*/
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "phy_led_mdix_regs.vh"

module phy_led_and_mdix_control_regs #(
  parameter CLK_HZ = `CLK_HZ
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  output reg irq_o,
  input wire rx_underflow_i,
  input wire rx_overflow_i,
  input wire tx_activity_i,
  input wire rx_activity_i,
  input wire collision_i,
  input wire link_up_i,
  input wire speed_100_i,
  input wire blink_enable_i,
  input wire auto_crossover_strap_i,
  input wire [11:10] local_advertised_ability_i,
  input wire [11:10] partner_advertised_ability_i,
  input wire full_duplex_i,
  output reg [1:0] elasticity_threshold_o,
  output reg auto_crossover_enable_o,
  output reg force_crossover_o,
  output reg pause_rx_o,
  output reg speed_led_out_o,
  output reg link_led_out_o,
  output reg activity_collision_led_out_o
);

  // two-flop synchronisers for every asynchronous input
  localparam NSYNC = 14;
  reg [NSYNC-1:0] sync1;
  reg [NSYNC-1:0] sync2;
  wire [NSYNC-1:0] raw_in;
  assign raw_in = {full_duplex_i, partner_advertised_ability_i, local_advertised_ability_i,
                   auto_crossover_strap_i, blink_enable_i, speed_100_i, link_up_i, collision_i,
                   rx_activity_i, tx_activity_i, rx_overflow_i, rx_underflow_i};

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= {NSYNC{1'b0}};
      sync2 <= {NSYNC{1'b0}};
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire s_unf = sync2[0];
  wire s_ovf = sync2[1];
  wire s_tx_act = sync2[2];
  wire s_rx_act = sync2[3];
  wire s_col = sync2[4];
  wire s_link = sync2[5];
  wire s_speed = sync2[6];
  wire s_blink_en = sync2[7];
  wire s_strap = sync2[8];
  wire [1:0] s_local = sync2[10:9];
  wire [1:0] s_partner = sync2[12:11];
  wire s_fdx = sync2[13];

  // counts the edges needed to fill the synchroniser after reset
  reg [1:0] sync_age;
  wire sync_ready = sync_age[1];

  // bus decode
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0] sel;
    input [15:0] wmask;
    reg [15:0] m;
    begin
      m = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
      merge16 = (old & ~m) | (wdat & m);
    end
  endfunction

  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire [5:0] idx = adr_i[7:2];
  wire wr = req & we_i;
  reg hit;
  always @* begin
    if (idx == `IDX_RMII_BYPASS) hit = 1'b1;
    else if (idx == `IDX_LED_CTRL) hit = 1'b1;
    else if (idx == `IDX_PHY_FUNC) hit = 1'b1;
    else if (idx == `IDX_IRQ_STATUS) hit = 1'b1;
    else if (idx == `IDX_IRQ_MASK) hit = 1'b1;
    else if (idx == `IDX_INDICATION) hit = 1'b1;
    else hit = 1'b0;
  end

  wire wr_rb = wr & (idx == `IDX_RMII_BYPASS);
  wire wr_lc = wr & (idx == `IDX_LED_CTRL);
  wire wr_pf = wr & (idx == `IDX_PHY_FUNC);
  wire wr_is = wr & (idx == `IDX_IRQ_STATUS);
  wire wr_im = wr & (idx == `IDX_IRQ_MASK);

  // stored register contents
  reg [15:0] led_ctrl;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg unf_flag;
  reg ovf_flag;
  reg unf_prev;
  reg ovf_prev;
  reg strap_taken;

  wire [15:0] rb_val = {12'h000, ovf_flag, unf_flag, elasticity_threshold_o};
  wire [15:0] pf_val = {auto_crossover_enable_o, force_crossover_o, pause_rx_o, 13'h0000};
  wire [15:0] lc_next = merge16(led_ctrl, dat_i[15:0], sel_i[1:0], `LC_WMASK); // RULE3
  wire [15:0] rb_next = merge16(rb_val, dat_i[15:0], sel_i[1:0], 16'h0003);
  wire [15:0] pf_next = merge16(pf_val, dat_i[15:0], sel_i[1:0], `PF_WMASK);

  wire unf_rise = s_unf & ~unf_prev;
  wire ovf_rise = s_ovf & ~ovf_prev;

  // status flags: set on a detected event, sticky until reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      unf_flag <= 1'b0;
      ovf_flag <= 1'b0;
      unf_prev <= 1'b0;
      ovf_prev <= 1'b0;
    end else begin
      unf_prev <= s_unf;
      ovf_prev <= s_ovf;
      if (unf_rise) unf_flag <= 1'b1; // RULE1
      if (ovf_rise) ovf_flag <= 1'b1; // RULE14
    end
  end

  // interrupt status: write one to clear, a new event wins over the clear
  wire [1:0] irq_events = {ovf_rise, unf_rise};
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~((wr_is & sel_i[0]) ? dat_i[1:0] : 2'h0)) | irq_events;
      if (wr_im & sel_i[0]) irq_mask <= dat_i[1:0];
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      led_ctrl <= 16'h0000;
      elasticity_threshold_o <= `RB_ELAST_RST; // RULE2
      force_crossover_o <= 1'b0;
      auto_crossover_enable_o <= 1'b0;
      strap_taken <= 1'b0;
    end else begin
      if (wr_lc) led_ctrl <= lc_next;
      if (wr_rb) elasticity_threshold_o <= rb_next[`RB_ELAST_HI:`RB_ELAST_LO]; // RULE2
      if (wr_pf) force_crossover_o <= pf_next[`PF_FORCE_X_BIT]; // RULE12
      // strap caught once after the synchroniser has filled
      if (!strap_taken && sync_ready) begin
        auto_crossover_enable_o <= s_strap; // RULE10
        strap_taken <= 1'b1;
      end else if (wr_pf) begin
        auto_crossover_enable_o <= pf_next[`PF_AUTO_X_BIT]; // RULE10
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) sync_age <= 2'h0;
    else if (!sync_ready) sync_age <= sync_age + 2'h1;
  end

  // pause resolution for the receive direction, full duplex only
  wire pause_resolved = s_fdx & ((s_local[0] & s_partner[0]) |
                                 (s_local[0] & s_local[1] & ~s_partner[0] & s_partner[1]));
  always @(posedge clk_i) begin
    if (rst_i) pause_rx_o <= 1'b0;
    else pause_rx_o <= pause_resolved; // RULE13
  end

  // LED drive
  wire blink_wave;
  blink_divider #(
    .CLK_HZ(CLK_HZ),
    .BASE_HZ(`BLINK_BASE_HZ)
  ) u_blink (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rate_i(led_ctrl[`LC_BLINK_HI:`LC_BLINK_LO]),
    .wave_o(blink_wave)
  );

  wire activity = led_ctrl[`LC_ACT_RX_BIT] ? s_rx_act : (s_rx_act | s_tx_act); // RULE5
  wire link_ind = s_link & ~(s_blink_en & activity & blink_wave); // RULE6
  wire act_ind = activity | s_col;

  always @(posedge clk_i) begin
    if (rst_i) begin
      speed_led_out_o <= 1'b0;
      link_led_out_o <= 1'b0;
      activity_collision_led_out_o <= 1'b0;
    end else begin
      speed_led_out_o <= led_ctrl[`LC_DRV_SPD_BIT] ? led_ctrl[`LC_SPD_VAL_BIT] : s_speed; // RULE7 RULE15
      link_led_out_o <= led_ctrl[`LC_DRV_LNK_BIT] ? led_ctrl[`LC_LNK_VAL_BIT] : link_ind; // RULE8 RULE15
      activity_collision_led_out_o <= led_ctrl[`LC_DRV_ACT_BIT] ? led_ctrl[`LC_ACT_VAL_BIT] : act_ind; // RULE9 RULE15
    end
  end

  // read mux; LED control reads stored bits only, not pin levels
  reg [15:0] rd;
  always @* begin
    if (idx == `IDX_RMII_BYPASS) rd = rb_val;
    else if (idx == `IDX_LED_CTRL) rd = led_ctrl & `LC_WMASK; // RULE3 RULE4
    else if (idx == `IDX_PHY_FUNC) rd = pf_val;
    else if (idx == `IDX_IRQ_STATUS) rd = {14'h0000, irq_status};
    else if (idx == `IDX_IRQ_MASK) rd = {14'h0000, irq_mask};
    else rd = {10'h000, s_fdx, s_col, s_rx_act, s_tx_act, s_speed, s_link};
  end

  // single wait state: ack one cycle after the request is seen
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req & hit;
      err_o <= req & ~hit;
      dat_o <= (req & hit & ~we_i) ? {16'h0000, rd} : 32'h00000000;
    end
  end
endmodule // phy_led_and_mdix_control_regs

`default_nettype wire

// [design/phy_led_mdix_regs.vh]
/*
  Register offsets, field positions, reset values and timing constants for the
  LED direct control and crossover control register bank.
  Assumes a 10 MHz system clock and a classic Wishbone master with 32-bit data.
*/
// Behaviour
// [RULE1] The underflow status bit at position 2 of the RMII/bypass register reads 1 once an underflow was seen.
// [RULE2] A read/write two-bit elasticity threshold at bits 1:0 resets to 01 and sets elastic buffer tolerance.
// [RULE3] LED control bits 15:9 ignore writes and read as zero.
// [RULE4] LED control reads return stored values only, never the LED pin levels.
// [RULE5] Activity source bit 8 set means receive traffic only, clear means transmit or receive.
// [RULE6] Blink rate field 7:6 picks 6, 12, 24 or 48 Hz for the link LED while blinking on activity.
// [RULE7] Speed override bit 5 drives the speed LED with forced value bit 2.
// [RULE8] Link override bit 4 drives the link LED with forced value bit 1.
// [RULE9] Activity override bit 3 drives the activity/collision LED with forced value bit 0.
// [RULE10] Control bit 15 enables automatic crossover, resets from a strap and is rewritable.
// [RULE11] Software keeps automatic crossover off whenever auto-negotiation is off.
// [RULE12] Control bit 14 set forces the media pairs crossed.
// [RULE13] Read-only bit 13 shows pause receive resolved from local and partner ability bits 11:10.
// [RULE14] The overflow status bit at position 3 of the RMII/bypass register reads 1 once an overflow was seen.
// [RULE15] With an override clear each LED follows its internal indication and the forced value is ignored.
`ifndef PHY_LED_MDIX_REGS_VH
`define PHY_LED_MDIX_REGS_VH

// register indices; byte address is four times the index
`define IDX_RMII_BYPASS 6'h17
`define IDX_LED_CTRL 6'h18
`define IDX_PHY_FUNC 6'h19
`define IDX_IRQ_STATUS 6'h1a
`define IDX_IRQ_MASK 6'h1b
`define IDX_INDICATION 6'h1c

`define RB_OVF_BIT 3
`define RB_UNF_BIT 2
`define RB_ELAST_HI 1
`define RB_ELAST_LO 0
`define RB_ELAST_RST 2'h1

`define LC_ACT_RX_BIT 8
`define LC_BLINK_HI 7
`define LC_BLINK_LO 6
`define LC_DRV_SPD_BIT 5
`define LC_DRV_LNK_BIT 4
`define LC_DRV_ACT_BIT 3
`define LC_SPD_VAL_BIT 2
`define LC_LNK_VAL_BIT 1
`define LC_ACT_VAL_BIT 0
`define LC_WMASK 16'h01ff

`define PF_AUTO_X_BIT 15
`define PF_FORCE_X_BIT 14
`define PF_PAUSE_RX_BIT 13
`define PF_WMASK 16'hc000

// interrupt status/mask bits
`define IRQ_UNF_BIT 0
`define IRQ_OVF_BIT 1
`define IRQ_WIDTH 2

// advertised ability: bit 10 symmetric pause, bit 11 asymmetric pause
`define ABIL_PAUSE_BIT 10
`define ABIL_ASYM_BIT 11

`define CLK_HZ 10000000
`define BLINK_BASE_HZ 6

`endif

// [verif/led_board.sv]
/* board status LEDs: reports how long the link LED held its last level.
   assumes active-high LED levels from the register bank. */
`timescale 1ns/1ps
`default_nettype none
module led_board (
  input wire logic clk_i,
  input wire logic link_i,
  output var logic [15:0] link_half_o
);
  logic [15:0] cnt = 16'h0;
  logic last = 1'b0;
  always @(posedge clk_i) begin
    last <= link_i;
    cnt <= (link_i != last) ? 16'h1 : cnt + 16'h1;
    if (link_i != last) begin
      link_half_o <= cnt;
    end
  end
endmodule // led_board
`default_nettype wire

// [verif/phy_led_and_mdix_control_regs_sva.sv]
/* port assertions for the register bank.
   assumes a classic Wishbone master holding the request through ack. */
`timescale 1ns/1ps
`default_nettype none
module regs_sva (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire [1:0] elasticity_threshold_o,
  input wire force_crossover_o,
  input wire speed_led_out_o,
  input wire link_led_out_o,
  input wire activity_collision_led_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  wire wl = ack_o && we_i && adr_i == 8'h60 && sel_i[0];
  property p_ack; req |=> (ack_o ^ err_o) ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bad answer");
  property p_err; req && adr_i[7:2] < 6'h17 |=> err_o && !ack_o; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_rsv; ack_o && !we_i && adr_i == 8'h60 |-> dat_o[31:9] == 23'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved nonzero");
  property p_rst; $fell(rst_i) |-> elasticity_threshold_o == 2'h1; endproperty
  a_rst: assert property (p_rst) else $error("threshold reset");
  property p_elast; ack_o && we_i && adr_i == 8'h5c && sel_i[0] |-> elasticity_threshold_o == dat_i[1:0]; endproperty
  a_elast: assert property (p_elast) else $error("threshold write");
  property p_force; ack_o && we_i && adr_i == 8'h64 && sel_i[1] |-> force_crossover_o == dat_i[14]; endproperty
  a_force: assert property (p_force) else $error("force write");
  property p_spd; wl && dat_i[5] |=> speed_led_out_o == $past(dat_i[2]); endproperty
  a_spd: assert property (p_spd) else $error("speed led");
  property p_lnk; wl && dat_i[4] |=> link_led_out_o == $past(dat_i[1]); endproperty
  a_lnk: assert property (p_lnk) else $error("link led");
  property p_act; wl && dat_i[3] |=> activity_collision_led_out_o == $past(dat_i[0]); endproperty
  a_act: assert property (p_act) else $error("activity led");
endmodule // regs_sva
bind phy_led_and_mdix_control_regs regs_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
  .dat_o, .ack_o, .err_o, .elasticity_threshold_o, .force_crossover_o, .speed_led_out_o, .link_led_out_o,
  .activity_collision_led_out_o);
`default_nettype wire

// [verif/tb_phy_led_and_mdix_control_regs.sv]
/* register access, LED, pause and interrupt tests of the register bank.
   assumes the board LED model and a 100 ns clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_phy_led_and_mdix_control_regs;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, e;
  logic [7:0] adr_i = 8'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, err_o, irq_o, unf = 0, ovf = 0, tx = 0, rx = 0, lnk = 0, spd = 0, bl = 0, fdx = 0;
  logic [1:0] la = 2'h0, pa = 2'h0;
  logic spd_o, lnk_o, act_o, ax_o, fx_o, prx_o;
  logic [15:0] link_half;
  logic [5:0] pt [5] = '{6'h2b, 6'h0a, 6'h3b, 6'h2c, 6'h3d};
  wire [31:0] leds = {29'h0, spd_o, lnk_o, act_o};
  int miscompares = 0, checked = 0, cycles = 0, d, h;
  phy_led_and_mdix_control_regs #(.CLK_HZ(1200)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'h3), .dat_i, .dat_o, .ack_o, .err_o, .irq_o, .rx_underflow_i(unf), .rx_overflow_i(ovf),
    .tx_activity_i(tx), .rx_activity_i(rx), .collision_i(1'b0), .link_up_i(lnk), .speed_100_i(spd),
    .blink_enable_i(bl), .auto_crossover_strap_i(1'b1), .local_advertised_ability_i(la),
    .partner_advertised_ability_i(pa), .full_duplex_i(fdx), .elasticity_threshold_o(),
    .auto_crossover_enable_o(ax_o), .force_crossover_o(fx_o), .pause_rx_o(prx_o),
    .speed_led_out_o(spd_o), .link_led_out_o(lnk_o), .activity_collision_led_out_o(act_o));
  led_board u_leds (.clk_i, .link_i(lnk_o), .link_half_o(link_half));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_sim;
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] v);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 16'h0, v};
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic pulse(input bit which);
    if (which) ovf <= 1'b1;
    else unf <= 1'b1;
    repeat (4) @(posedge clk_i);
    if (which) ovf <= 1'b0;
    else unf <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(8'h5c, 0, 0); check(q & 32'hf, 32'h1);
    wb(8'h5c, 1, 3); wb(8'h5c, 0, 0); check(q & 32'h3, 32'h3);
    wb(8'h64, 0, 0); check(q & 32'he000, 32'h8000);
    wb(8'h64, 1, 16'h4000);
    wb(8'h64, 0, 0); check({q[15:14], ax_o, fx_o}, 32'h5);
    wb(8'h60, 1, 16'hffff); wb(8'h60, 0, 0); check(q, 32'h1ff);
    repeat (4) @(posedge clk_i); check(leds, 32'h7);
    wb(8'h60, 1, 16'h0007); repeat (4) @(posedge clk_i); check(leds, 32'h0);
    {lnk, spd, tx} <= 3'b111;
    wb(8'h60, 1, 16'h0100); repeat (4) @(posedge clk_i); check(leds, 32'h6);
    wb(8'h60, 0, 0); check(q, 32'h100);
    wb(8'h60, 1, 16'h0000); repeat (4) @(posedge clk_i); check(leds, 32'h7);
    bl <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      h = 100 >> r;
      wb(8'h60, 1, 16'(r << 6));
      repeat (4 * h + 10) @(posedge clk_i);
      d = int'(link_half) - h;
      check((d >= -1 && d <= 1) ? 32'(h) : {16'h0, link_half}, 32'(h));
    end
    bl <= 1'b0;
    foreach (pt[i]) begin
      {fdx, la, pa} <= pt[i][5:1];
      repeat (4) @(posedge clk_i);
      wb(8'h64, 0, 0); check({q[13], prx_o}, {30'h0, {2{pt[i][0]}}});
    end
    pulse(1'b0);
    wb(8'h5c, 0, 0); check(q & 32'hc, 32'h4);
    check({31'h0, irq_o}, 32'h0);
    wb(8'h6c, 1, 1); repeat (2) @(posedge clk_i); check({31'h0, irq_o}, 32'h1);
    wb(8'h68, 1, 1); repeat (2) @(posedge clk_i); check({31'h0, irq_o}, 32'h0);
    wb(8'h68, 0, 0); check(q & 32'h3, 32'h0);
    pulse(1'b1);
    wb(8'h5c, 0, 0); check(q & 32'hc, 32'hc);
    wb(8'h00, 0, 0); check({31'h0, e}, 32'h1);
    end_sim();
  end
endmodule // tb_phy_led_and_mdix_control_regs
`default_nettype wire
